// *** hw/csrs_pkg.sv ***
package csrs_pkg;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int unsigned MCLK_PERIOD_NS       = 40;
    localparam int unsigned MOD_CYCLE_CLKS       = 128;
    localparam int unsigned SETTLE_PERIODS       = 3;
    localparam int unsigned READY_HIGH_CLKS      = 500;
    localparam int unsigned RATE_W               = 8;
    localparam int unsigned CNT_W                = 24;
    localparam logic [1:0]  SETTLE_PERIODS_V     = 2'h3;
    localparam logic [8:0]  READY_HIGH_V         = 9'h1F4;
    localparam logic [6:0]  MOD_CYCLE_LAST       = 7'h7F;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        RESULT_READY_N_RST   = 1'h1;
    localparam logic [15:0] DATA_RST             = 16'h0000;

    typedef enum logic [3:0] {
        CSRS_HALT   = 4'h1,
        CSRS_SETTLE = 4'h2,
        CSRS_RUN    = 4'h4,
        CSRS_POWER_DOWN_REQUEST   = 4'h8
    } csrs_state_t;

    typedef struct packed {
        logic        filter_sync_hold;
        logic        power_down_request;
        logic [RATE_W-1:0] update_rate;
    } csrs_ctrl_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } csrs_sample_t;

    typedef struct packed {
        csrs_state_t        state;
        logic               fs_s1;
        logic               fs_s2;
        logic               pd_s1;
        logic               pd_s2;
        logic               rd_s1;
        logic               rd_s2;
        logic               rd_prev;
        logic [6:0]         mod_cnt;
        logic [RATE_W-1:0]  mod_in_period;
        logic [1:0]         settle_cnt;
        logic [8:0]         pulse_cnt;
        logic               result_ready_n;
        logic               unread;
        logic               filter_run;
        logic [15:0]        data;
    } csrs_regs_t;

endpackage

// *** hw/csrs_conv_ctrl.sv ***
`timescale 1ns/1ps
// Contract
// RQ1: Filter-sync high holds modulator and filter in reset, no samples processed.
// RQ2: Filter-sync written 0 releases filter; sampling resumes on next clock edge. Code raises filter_run on the third mclk_i edge, after the two-flop sync.
// RQ3: Filter-sync touches only modulator/filter state, never configuration.
// RQ4: After filter-sync release, no result loads before three update periods.
// RQ5: Software start-convert by filter-sync write; completion is result-ready falling.
// RQ6: Unread result at filter-sync release keeps result-ready low.
// RQ7: Update while result-ready low pulses it high 500 clocks, then low.
// RQ8: Data read sets result-ready high until settled fresh result loads.
// RQ9: Reset input clears all logic, filter, modulator and registers.
// RQ10: During reset result-ready high, register accesses ignored.
// RQ11: After reset release, default conversion; result-ready low after three periods.
// RQ12: Host should reprogram and calibrate after reset; recommendation only.
// RQ13: Master clock output keeps toggling while reset held low.
// RQ14: Standby powers down conversion, keeps all registers and data.
// RQ15: Standby written 0 resumes; new result three update periods later.
// RQ16: Standby changes neither interface nor result-ready level.
// RQ17: Pending result readable in standby; read completion sets result-ready high.
// RQ18: During standby oscillator runs, master clock uninterrupted.
// RQ19: Result-ready driven high stays high until valid new result written.
// RQ20: Modulator cycle is 128 master clock periods.
// RQ21: Update period derives from external update-rate setting.
module csrs_conv_ctrl
    import csrs_pkg::*;
(
    input  wire logic         mclk_i,            // Master clock, 25 MHz
    input  wire logic         reset_n_i,         // Async reset pin, active low
    input  wire csrs_ctrl_t   ctrl_i,            // Sync/standby bits and rate (pins)
    input  wire csrs_sample_t sample_i,          // Filter output word
    input  wire logic         data_read_done_i,  // Data register read finished
    output logic              result_ready_n_o,  // Result ready, active low
    output logic [15:0]       data_o,            // Output data register
    output logic              filter_run_o,      // Modulator/filter out of reset
    output logic              mclk_o             // Master clock divided by two
);

    csrs_regs_t r_reg;
    csrs_regs_t r_next;
    logic       rd_edge;
    logic       period_tick;
    logic       load;

    // --------------------------------------------------------
    // Master clock output
    // --------------------------------------------------------
    // Never gated: toggles through reset and standby   see RQ13 see RQ18
    // No reset here, so the if form settles an unknown start level
    always_ff @(negedge mclk_i) begin
        if (mclk_o) begin
            mclk_o <= 1'b0;
        end else begin
            mclk_o <= 1'b1;
        end
    end

    // --------------------------------------------------------
    // Next state
    // --------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        // Sync, standby and read-done inputs pass two flops before use; update_rate is used directly
        r_next.fs_s1   = ctrl_i.filter_sync_hold;
        r_next.fs_s2   = r_reg.fs_s1;
        r_next.pd_s1   = ctrl_i.power_down_request;
        r_next.pd_s2   = r_reg.pd_s1;
        r_next.rd_s1   = data_read_done_i;
        r_next.rd_s2   = r_reg.rd_s1;
        r_next.rd_prev = r_reg.rd_s2;
        rd_edge        = r_reg.rd_s2 & ~r_reg.rd_prev;

        // Modulator cycle counter; update period = rate modulator cycles
        r_next.mod_cnt = r_reg.mod_cnt + 7'h01;                       // see RQ20
        period_tick    = 1'b0;
        if (r_reg.mod_cnt == MOD_CYCLE_LAST) begin
            if (r_reg.mod_in_period >= ctrl_i.update_rate - 8'h01) begin  // see RQ21
                r_next.mod_in_period = '0;
                period_tick          = 1'b1;
            end else begin
                r_next.mod_in_period = r_reg.mod_in_period + 8'h01;
            end
        end
        load = 1'b0;

        case (r_reg.state)
            CSRS_HALT: begin
                // Filter held, nothing sampled                      see RQ1
                r_next.filter_run = 1'b0;
                r_next.mod_cnt    = '0;
                r_next.mod_in_period = '0;
                if (!r_reg.fs_s2) begin
                    r_next.state      = CSRS_SETTLE;                  // see RQ2
                    r_next.filter_run = 1'b1;
                    r_next.settle_cnt = '0;
                end
            end
            CSRS_SETTLE: begin
                // Three full periods before any load                  see RQ4 see RQ11 see RQ15
                if (period_tick) begin
                    r_next.settle_cnt = r_reg.settle_cnt + 2'h1;
                    if (r_reg.settle_cnt == SETTLE_PERIODS_V - 2'h1) begin
                        r_next.state = CSRS_RUN;
                        load         = sample_i.valid;
                    end
                end
            end
            CSRS_RUN: begin
                load = period_tick & sample_i.valid;
            end
            CSRS_POWER_DOWN_REQUEST: begin
                // Registers and data kept; conversion off             see RQ14
                r_next.filter_run = 1'b0;
                r_next.mod_cnt    = '0;
                r_next.mod_in_period = '0;
                if (!r_reg.pd_s2) begin
                    r_next.state      = CSRS_SETTLE;                  // see RQ15
                    r_next.filter_run = 1'b1;
                    r_next.settle_cnt = '0;
                end
            end
            default: begin
                r_next.state = CSRS_HALT;
            end
        endcase

        // Sync outranks standby; only filter state touched      see RQ3
        if (r_reg.fs_s2) begin
            r_next.state      = CSRS_HALT;
            r_next.filter_run = 1'b0;
        end else if (r_reg.pd_s2 && r_reg.state != CSRS_POWER_DOWN_REQUEST
                     && r_reg.state != CSRS_HALT) begin
            r_next.state      = CSRS_POWER_DOWN_REQUEST;
            r_next.filter_run = 1'b0;
        end

        // --------------------------------------------------------
        // Result-ready handshake
        // --------------------------------------------------------
        // Sync/standby never change the level directly       see RQ6 see RQ16
        if (r_reg.pulse_cnt != '0) begin
            r_next.pulse_cnt = r_reg.pulse_cnt - 9'h001;
            if (r_reg.pulse_cnt == 9'h001) begin
                r_next.result_ready_n = 1'b0;                         // see RQ7
            end
        end
        // Read works in any state, standby too                  see RQ8 see RQ17
        if (rd_edge) begin
            r_next.unread         = 1'b0;
            r_next.result_ready_n = 1'b1;
            r_next.pulse_cnt      = '0;
        end
        // Load wins over a same-cycle read
        if (load) begin
            r_next.data   = sample_i.data;
            r_next.unread = 1'b1;
            if (!r_reg.result_ready_n) begin
                r_next.result_ready_n = 1'b1;                         // see RQ7
                r_next.pulse_cnt      = READY_HIGH_V;
            end else if (r_reg.pulse_cnt == '0 || rd_edge) begin
                // Falling edge marks completion              see RQ5 see RQ19
                r_next.result_ready_n = 1'b0;
                r_next.pulse_cnt      = '0;
            end
        end
    end

    // --------------------------------------------------------
    // State register
    // --------------------------------------------------------
    // Everything to defaults; ready held high in reset  see RQ9 see RQ10
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r_reg                <= '0;
            r_reg.state          <= CSRS_SETTLE;
            r_reg.result_ready_n <= RESULT_READY_N_RST;
            r_reg.filter_run     <= 1'b1;
            r_reg.data           <= DATA_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign result_ready_n_o = r_reg.result_ready_n;
    assign data_o           = r_reg.data;
    assign filter_run_o     = r_reg.filter_run;

endmodule

// *** bench/csrs_conv_ctrl_asserts.sv ***
`timescale 1ns/1ps
module csrs_conv_ctrl_asserts
    import csrs_pkg::*;
(
    input  wire logic         mclk_i,           // Master clock
    input  wire logic         reset_n_i,        // Reset, active low
    input  wire csrs_ctrl_t   ctrl_i,           // Sync, standby, rate
    input  wire csrs_sample_t sample_i,         // Filter word
    input  wire logic         data_read_done_i, // Read finished
    input  wire logic         result_ready_n_o, // Result ready, active low
    input  wire logic [15:0]  data_o,           // Data register
    input  wire logic         filter_run_o,     // Filter released
    input  wire logic         mclk_o            // Clock out
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic [15:0] run_clks;
    logic [9:0]  hi_clks;
    logic        pulse;
    // Saturating, so a long run never wraps into a false early load
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_clks <= 16'h0000;
            hi_clks  <= 10'h000;
            pulse    <= 1'b0;
        end else begin
            run_clks <= filter_run_o ? run_clks + {15'h0000, ~&run_clks} : 16'h0000;
            hi_clks  <= result_ready_n_o ? hi_clks + 10'h001 : 10'h000;
            pulse    <= result_ready_n_o && (pulse || ($rose(result_ready_n_o) && $changed(data_o)));
        end
    end
    sequence s_release;
        ($fell(ctrl_i.filter_sync_hold) && !ctrl_i.power_down_request) ##1
            (!ctrl_i.filter_sync_hold && !ctrl_i.power_down_request) [*4];
    endsequence
    AST_SYNC_HOLD: assert property (ctrl_i.filter_sync_hold [*5] |-> !filter_run_o)
        else $error("filter runs while held");
    AST_SYNC_FREE: assert property (s_release |-> filter_run_o)
        else $error("filter not released");
    AST_LOAD_LATE: assert property ($changed(data_o) |->
        run_clks >= {ctrl_i.update_rate, 8'h00} + {1'b0, ctrl_i.update_rate, 7'h00})
        else $error("result loaded before settling");
    AST_PULSE_LEN: assert property ($fell(result_ready_n_o) && pulse |-> hi_clks == 10'h1F4)
        else $error("update pulse length wrong");
    AST_READ_HIGH: assert property ($rose(data_read_done_i) |-> ##[1:6] result_ready_n_o)
        else $error("read did not raise ready");
    AST_LOW_NEEDS_LOAD: assert property ($fell(result_ready_n_o) && !pulse |-> $changed(data_o))
        else $error("ready fell without new result");
    AST_POWER_DOWN_REQUEST_KEEP: assert property ((ctrl_i.power_down_request && !ctrl_i.filter_sync_hold) [*5]
        |-> $stable(data_o))
        else $error("data changed in standby");
    AST_RST_CLEAR: assert property ($rose(reset_n_i) |-> result_ready_n_o && data_o == 16'h0000)
        else $error("outputs not at defaults after reset");
    AST_MCLK_RUN: assert property (disable iff (1'b0) $fell(mclk_o) |=> $rose(mclk_o))
        else $error("clock out stopped");
endmodule
bind csrs_conv_ctrl csrs_conv_ctrl_asserts u_asserts (.mclk_i, .reset_n_i, .ctrl_i, .sample_i,
    .data_read_done_i, .result_ready_n_o, .data_o, .filter_run_o, .mclk_o);

// *** bench/csrs_host_model.sv ***
`timescale 1ns/1ps
module csrs_host_model (
    input  wire logic clk_i,            // Master clock
    input  wire logic reset_n_i,        // Reset, active low
    input  wire logic result_ready_n_i, // Ready from device
    input  wire logic read_en_i,        // Reads allowed
    input  wire logic slow_i,           // Long delay before read
    output logic      read_done_o       // Read finished, level
);
    logic [7:0] wait_cnt;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_cnt    <= 8'h00;
            read_done_o <= 1'b0;
        end else if (wait_cnt != 8'h00) begin
            wait_cnt    <= wait_cnt - 8'h01;
            read_done_o <= wait_cnt <= 8'h04;
        end else begin
            read_done_o <= 1'b0;
            if (read_en_i && !result_ready_n_i && !read_done_o) begin
                wait_cnt <= slow_i ? 8'h2C : 8'h06;
            end
        end
    end
endmodule

// *** bench/csrs_conv_ctrl_test.sv ***
`timescale 1ns/1ps
module csrs_conv_ctrl_test
    import csrs_pkg::*;
;
    logic         mclk;
    logic         reset_n;
    csrs_ctrl_t   ctrl;
    csrs_sample_t sample;
    logic         rd_done;
    logic         rd_en;
    logic         slow;
    logic         ready_n;
    logic [15:0]  data;
    logic         run;
    logic         mclk_out;
    int           err_total;
    int           comparisons;
    csrs_conv_ctrl dut (.mclk_i(mclk), .reset_n_i(reset_n), .ctrl_i(ctrl), .sample_i(sample),
        .data_read_done_i(rd_done), .result_ready_n_o(ready_n), .data_o(data),
        .filter_run_o(run), .mclk_o(mclk_out));
    csrs_host_model host (.clk_i(mclk), .reset_n_i(reset_n), .result_ready_n_i(ready_n),
        .read_en_i(rd_en), .slow_i(slow), .read_done_o(rd_done));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) sample.data <= sample.data + 16'h0001;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_rdy(input logic lvl, output int n);
        n = 0;
        while (ready_n !== lvl && n < 5000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Rate 8 gives 1024-clock periods, longer than the 500-clock pulse
    task automatic t_reset;
        int   n;
        logic m0;
        cyc(3);
        m0 = mclk_out;
        cyc(1);
        chk(mclk_out != m0, 1'b1);
        chk(ready_n, 1'b1);
        chk(data, 16'h0000);
        reset_n <= 1'b1;
        ctrl    <= '{1'b0, 1'b0, 8'h08};
        wait_rdy(1'b0, n);
        chk(n >= 2048 && n <= 3100, 1'b1);
        $display("reset test done");
    endtask
    task automatic t_sync_unread;
        int n;
        ctrl.filter_sync_hold <= 1'b1;
        cyc(10);
        chk(run, 1'b0);
        ctrl.filter_sync_hold <= 1'b0;
        cyc(6);
        chk(run, 1'b1);
        chk(ready_n, 1'b0);
        wait_rdy(1'b1, n);
        chk(n >= 2042 && n <= 3100, 1'b1);
        wait_rdy(1'b0, n);
        chk(16'(n), 16'h01F4);
        $display("sync with unread result done");
    endtask
    task automatic t_start_convert;
        int n;
        rd_en <= 1'b1;
        slow  <= 1'b1;
        wait_rdy(1'b1, n);
        rd_en <= 1'b0;
        chk(n <= 60, 1'b1);
        ctrl.filter_sync_hold <= 1'b1;
        cyc(4);
        ctrl.filter_sync_hold <= 1'b0;
        cyc(1000);
        chk(ready_n, 1'b1);
        wait_rdy(1'b0, n);
        chk(n + 1000 >= 2048 && n + 1000 <= 3100, 1'b1);
        $display("start convert done");
    endtask
    task automatic t_standby;
        int          n;
        logic [15:0] held;
        logic        m0;
        ctrl.power_down_request <= 1'b1;
        cyc(10);
        held = data;
        cyc(1500);
        chk(data, held);
        m0 = mclk_out;
        cyc(1);
        chk(mclk_out != m0, 1'b1);
        chk(ready_n, 1'b0);
        rd_en <= 1'b1;
        slow  <= 1'b0;
        wait_rdy(1'b1, n);
        rd_en <= 1'b0;
        chk(n <= 16, 1'b1);
        cyc(1500);
        chk(ready_n, 1'b1);
        ctrl.power_down_request <= 1'b0;
        wait_rdy(1'b0, n);
        chk(n >= 2048 && n <= 3100, 1'b1);
        $display("standby done");
    endtask
    initial begin
        reset_n     = 1'b0;
        ctrl        = '{1'b0, 1'b0, 8'h08};
        sample      = '{1'b1, 16'h0001};
        rd_en       = 1'b0;
        slow        = 1'b0;
        err_total   = 0;
        comparisons = 0;
        t_reset();
        t_sync_unread();
        t_start_convert();
        t_standby();
        stop_test();
    end
    initial begin
        cyc(40000);
        err_total++;
        stop_test();
    end
endmodule
